// ---- pkg/ssc_pkg.sv ----
// Constants, register map and span presets for the SPI span config block
package ssc_pkg;
   localparam int ADDR_W = 15;
   localparam int CNT_W = 5;
   localparam logic [4:0] INST_SHORT = 5'h08;
   localparam logic [4:0] INST_LONG = 5'h10;
   localparam logic [4:0] BYTE_BITS = 5'h08;
   // Register addresses
   localparam logic [14:0] A_IFA = 15'h0000;
   localparam logic [14:0] A_IFB = 15'h0001;
   localparam logic [14:0] A_STA = 15'h0003;
   localparam logic [14:0] A_REF = 15'h000a;
   localparam logic [14:0] A_SPAN = 15'h000b;
   localparam logic [14:0] A_GAIN = 15'h000c;
   localparam logic [14:0] A_OFF = 15'h000d;
   localparam logic [14:0] A_DACL = 15'h000e;
   localparam logic [14:0] A_DACH = 15'h000f;
   // Field positions
   localparam int IFA_DIR = 5;
   localparam int IFB_COMPACT = 3;
   localparam int IFB_SINGLE = 7;
   localparam int STA_BITCNT = 4;
   localparam int STA_SPLIT = 5;
   localparam int GAIN_EN = 7;
   localparam int GAIN_P_LO = 5;
   localparam int GAIN_N_LO = 3;
   localparam int GAIN_SIGN = 2;
   localparam int GAIN_OFF8 = 0;
   localparam int SHIFT_W = 2;
   localparam int SPAN_W = 3;
   // Write masks and reset values
   localparam logic [7:0] IFA_MASK = 8'h20;
   localparam logic [7:0] IFB_MASK = 8'h88;
   localparam logic [7:0] STA_MASK = 8'h30;
   localparam logic [7:0] GAIN_MASK = 8'hfd;
   localparam logic [7:0] IFA_RST = 8'h00;
   localparam logic [7:0] IFB_RST = 8'h08;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] DAC_RST = 16'h0000;
   localparam logic [1:0] REF_INT_HIZ = 2'h0;
   localparam logic [1:0] REF_INT_OUT = 2'h1;
   localparam logic [2:0] SPAN_RST = 3'h0;
   // Span presets, offsets as 10-bit two's complement over 1024
   localparam logic [1:0] PRE_N_2V5 = 2'h3;
   localparam logic [1:0] PRE_ZERO = 2'h0;
   localparam logic [9:0] PRE_OFF_2V5 = 10'h3d0;
   localparam logic [9:0] PRE_OFF_5V = 10'h000;
   localparam logic [9:0] PRE_OFF_10V = 10'h1ef;
   localparam logic [9:0] PRE_OFF_PM5V = 10'h211;
   localparam logic [9:0] PRE_OFF_PM10V = 10'h30b;
   typedef enum logic [2:0] {
      SPAN_2V5, SPAN_5V, SPAN_10V, SPAN_PM5V, SPAN_PM10V
   } ssc_span_type;
endpackage

// ---- verilog/ssc_top.sv ----
// SPI register access and output span configuration
`timescale 1ns/1ps
module ssc_top (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic spi_clk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sdi_in,
   output logic spi_sdo_out,
   output logic spi_sdo_oe_n_out,
   output logic [2:0] span_select_out,
   output logic custom_span_out,
   output logic [1:0] positive_gain_shift_out,
   output logic [1:0] negative_gain_shift_out,
   output logic [9:0] offset_out,
   output logic [15:0] dac_code_out,
   output logic ref_internal_out,
   output logic ref_pin_oe_n_out
);
   // Configuration registers, reference clock domain
   logic [7:0] ifa_q;
   logic [7:0] ifb_q;
   logic [7:0] sta_q;
   logic [7:0] gain_q;
   logic [7:0] off_q;
   logic [1:0] ref_q;
   logic [2:0] span_q;
   logic [15:0] dac_q;
   logic [7:0] stage_q;
   logic [14:0] pend_addr_q;
   logic pend_q;

   // Serial side state, link clock domain
   logic act_q;
   logic [4:0] cnt_q, cnt_d, cnt_c;
   logic dat_q, dat_d, dat_c;
   logic rw_q, rw_d;
   logic fb_q, fb_d;
   logic [14:0] addr_q, addr_d;
   logic [15:0] sh_d;
   logic [15:0] sh_q;
   logic [7:0] out_q, out_d;
   logic [14:0] wr_addr_q, wr_addr_d;
   logic [7:0] wr_byte_q, wr_byte_d;
   logic wr_first_q, wr_first_d;
   logic wr_tgl_q, wr_tgl_d;
   logic sdo_q;

   // Mode bits are static between frames, so read directly
   wire frame_rst = spi_cs_n_in | ~rst_n_in;
   wire first = ~act_q;
   wire compact = ifb_q[ssc_pkg::IFB_COMPACT];
   wire single = ifb_q[ssc_pkg::IFB_SINGLE];
   wire step_up = ifa_q[ssc_pkg::IFA_DIR];
   wire [4:0] inst_len = compact ? ssc_pkg::INST_SHORT
                                 : ssc_pkg::INST_LONG;

   function automatic logic [7:0] read_reg(input logic [14:0] a);
      logic [7:0] v;
      v = ssc_pkg::BYTE_RST;
      if (a == ssc_pkg::A_IFA) v = ifa_q;
      if (a == ssc_pkg::A_IFB) v = ifb_q;
      if (a == ssc_pkg::A_STA) v = sta_q;
      if (a == ssc_pkg::A_REF) v = {6'h00, ref_q};
      if (a == ssc_pkg::A_SPAN) v = {5'h00, span_q};
      if (a == ssc_pkg::A_GAIN) v = gain_q;
      if (a == ssc_pkg::A_OFF) v = off_q;
      if (a == ssc_pkg::A_DACL) v = dac_q[7:0];
      if (a == ssc_pkg::A_DACH) v = dac_q[15:8];
      return v;
   endfunction

   // Frame open flag, cleared whenever chip select is high
   always_ff @(posedge spi_clk_in or posedge frame_rst) begin
      if (frame_rst) begin
         act_q <= 1'b0;
      end else begin
         act_q <= 1'b1;
      end
   end

   always_comb begin
      cnt_c = first ? '0 : cnt_q;
      dat_c = first ? 1'b0 : dat_q;
      sh_d = {sh_q[14:0], spi_sdi_in};
      cnt_d = cnt_c + 5'h01;
      dat_d = dat_c;
      rw_d = rw_q;
      fb_d = fb_q;
      addr_d = addr_q;
      out_d = out_q;
      wr_addr_d = wr_addr_q;
      wr_byte_d = wr_byte_q;
      wr_first_d = wr_first_q;
      wr_tgl_d = wr_tgl_q;
      if (!dat_c) begin
         if (cnt_d == inst_len) begin
            rw_d = compact ? sh_d[7] : sh_d[15];
            addr_d = compact ? {8'h00, sh_d[6:0]} : sh_d[14:0];
            dat_d = 1'b1;
            cnt_d = '0;
            fb_d = 1'b1;
            out_d = read_reg(addr_d);
         end
      end else if (cnt_d == ssc_pkg::BYTE_BITS) begin
         cnt_d = '0;
         fb_d = 1'b0;
         if (!rw_q) begin
            wr_addr_d = addr_q;
            wr_byte_d = sh_d[7:0];
            wr_first_d = fb_q;
            wr_tgl_d = ~wr_tgl_q;
         end
         addr_d = step_up ? addr_q + 15'h0001
                          : addr_q - 15'h0001;
         out_d = read_reg(addr_d);
         if (single) begin
            dat_d = 1'b0;
         end
      end
   end

   // Serial clock flops update only inside a frame
   always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         dat_q <= 1'b0;
         rw_q <= 1'b0;
         fb_q <= 1'b0;
         addr_q <= '0;
         sh_q <= '0;
         out_q <= ssc_pkg::BYTE_RST;
         wr_addr_q <= '0;
         wr_byte_q <= ssc_pkg::BYTE_RST;
         wr_first_q <= 1'b0;
         wr_tgl_q <= 1'b0;
      end else if (!spi_cs_n_in) begin
         cnt_q <= cnt_d;
         dat_q <= dat_d;
         rw_q <= rw_d;
         fb_q <= fb_d;
         addr_q <= addr_d;
         sh_q <= sh_d;
         out_q <= out_d;
         wr_addr_q <= wr_addr_d;
         wr_byte_q <= wr_byte_d;
         wr_first_q <= wr_first_d;
         wr_tgl_q <= wr_tgl_d;
      end
   end

   // Read data changes on falling edges, sampled by host on rising
   // Chip select high clears it at once, not at the next stray edge
   wire [2:0] sdo_idx = ~cnt_q[2:0];
   wire sdo_nx = dat_q & rw_q & out_q[sdo_idx];
   always_ff @(negedge spi_clk_in or posedge frame_rst) begin
      if (frame_rst) begin
         sdo_q <= 1'b0;
      end else begin
         sdo_q <= sdo_nx;
      end
   end

   assign spi_sdo_out = sdo_q;
   assign spi_sdo_oe_n_out = ~(act_q & dat_q & rw_q);

   // Crossing of write events and frame end into reference domain
   logic cs_s1_q;
   logic cs_s2_q;
   logic cs_s3_q;
   logic tg_s1_q;
   logic tg_s2_q;
   logic tg_s3_q;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         tg_s1_q <= 1'b0;
         tg_s2_q <= 1'b0;
         tg_s3_q <= 1'b0;
      end else begin
         cs_s1_q <= spi_cs_n_in;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         tg_s1_q <= wr_tgl_q;
         tg_s2_q <= tg_s1_q;
         tg_s3_q <= tg_s2_q;
      end
   end

   // Serial state is frozen while chip select is high
   wire wr_ev = tg_s2_q ^ tg_s3_q;
   wire cs_rise = cs_s2_q & ~cs_s3_q;
   wire we_ifa = wr_ev && wr_addr_q == ssc_pkg::A_IFA;
   wire we_ifb = wr_ev && wr_addr_q == ssc_pkg::A_IFB;
   wire we_sta = wr_ev && wr_addr_q == ssc_pkg::A_STA;
   wire we_ref = wr_ev && wr_addr_q == ssc_pkg::A_REF;
   wire we_span = wr_ev && wr_addr_q == ssc_pkg::A_SPAN;
   wire we_gain = wr_ev && wr_addr_q == ssc_pkg::A_GAIN;
   wire we_off = wr_ev && wr_addr_q == ssc_pkg::A_OFF;
   wire dac_hi = wr_addr_q == ssc_pkg::A_DACH;
   wire dac_hit = wr_ev && (dac_hi || wr_addr_q == ssc_pkg::A_DACL);
   wire commit = dac_hit && pend_q && !wr_first_q
                 && wr_addr_q != pend_addr_q;
   wire pend_nx = commit ? 1'b0 : (dac_hit ? 1'b1 : pend_q);
   // Frame end judges a cut byte; an unpaired code half is judged at frame end or at a first code byte while one is pending
   wire split_set = (dac_hit && pend_q && wr_first_q)
                    || (cs_rise && pend_nx);
   wire bit_set = cs_rise && dat_q && !rw_q
                  && cnt_q != '0;
   wire [15:0] dac_d = dac_hi ? {wr_byte_q, stage_q}
                              : {stage_q, wr_byte_q};
   wire [7:0] sta_clr = we_sta ? wr_byte_q : 8'h00;
   logic [7:0] sta_set;

   always_comb begin
      sta_set = 8'h00;
      sta_set[ssc_pkg::STA_BITCNT] = bit_set;
      sta_set[ssc_pkg::STA_SPLIT] = split_set;
   end

   // Set wins over a same-cycle write-one clear
   wire [7:0] sta_d = (sta_set | (sta_q & ~sta_clr)) & ssc_pkg::STA_MASK;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ifa_q <= ssc_pkg::IFA_RST;
         ifb_q <= ssc_pkg::IFB_RST;
         sta_q <= ssc_pkg::BYTE_RST;
         ref_q <= ssc_pkg::REF_INT_HIZ;
         span_q <= ssc_pkg::SPAN_RST;
         gain_q <= ssc_pkg::BYTE_RST;
         off_q <= ssc_pkg::BYTE_RST;
      end else begin
         sta_q <= sta_d;
         if (we_ifa) ifa_q <= wr_byte_q & ssc_pkg::IFA_MASK;
         if (we_ifb) ifb_q <= wr_byte_q & ssc_pkg::IFB_MASK;
         if (we_ref) ref_q <= wr_byte_q[1:0];
         if (we_span) span_q <= wr_byte_q[2:0];
         if (we_gain) gain_q <= wr_byte_q & ssc_pkg::GAIN_MASK;
         if (we_off) off_q <= wr_byte_q;
      end
   end

   // Two-byte code staging
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         dac_q <= ssc_pkg::DAC_RST;
         stage_q <= ssc_pkg::BYTE_RST;
         pend_addr_q <= '0;
         pend_q <= 1'b0;
      end else begin
         pend_q <= cs_rise ? 1'b0 : pend_nx;
         if (commit) dac_q <= dac_d;
         if (dac_hit && !commit) begin
            stage_q <= wr_byte_q;
            pend_addr_q <= wr_addr_q;
         end
      end
   end

   // Effective span parameters
   logic [1:0] pre_p;
   logic [1:0] pre_n;
   logic [9:0] pre_off;
   wire custom = gain_q[ssc_pkg::GAIN_EN];
   wire [8:0] mag = {gain_q[ssc_pkg::GAIN_OFF8], off_q};
   wire [9:0] mag_w = {1'b0, mag};
   wire [9:0] own_off = gain_q[ssc_pkg::GAIN_SIGN] ? 10'(~mag_w + 10'h001)
                                                  : mag_w;
   wire [1:0] own_p = gain_q[ssc_pkg::GAIN_P_LO +: ssc_pkg::SHIFT_W];
   wire [1:0] own_n = gain_q[ssc_pkg::GAIN_N_LO +: ssc_pkg::SHIFT_W];

   always_comb begin
      pre_p = ssc_pkg::PRE_ZERO;
      pre_n = ssc_pkg::PRE_ZERO;
      pre_off = ssc_pkg::PRE_OFF_5V;
      unique case (ssc_pkg::ssc_span_type'(span_q))
         ssc_pkg::SPAN_2V5: begin
            pre_n = ssc_pkg::PRE_N_2V5;
            pre_off = ssc_pkg::PRE_OFF_2V5;
         end
         ssc_pkg::SPAN_5V: pre_off = ssc_pkg::PRE_OFF_5V;
         ssc_pkg::SPAN_10V: pre_off = ssc_pkg::PRE_OFF_10V;
         ssc_pkg::SPAN_PM5V: pre_off = ssc_pkg::PRE_OFF_PM5V;
         ssc_pkg::SPAN_PM10V: pre_off = ssc_pkg::PRE_OFF_PM10V;
         default: begin
            pre_n = ssc_pkg::PRE_N_2V5;
            pre_off = ssc_pkg::PRE_OFF_2V5;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         span_select_out <= ssc_pkg::SPAN_RST;
         custom_span_out <= 1'b0;
         positive_gain_shift_out <= ssc_pkg::PRE_ZERO;
         negative_gain_shift_out <= ssc_pkg::PRE_N_2V5;
         offset_out <= ssc_pkg::PRE_OFF_2V5;
         dac_code_out <= ssc_pkg::DAC_RST;
         ref_internal_out <= 1'b1;
         ref_pin_oe_n_out <= 1'b1;
      end else begin
         span_select_out <= span_q;
         custom_span_out <= custom;
         positive_gain_shift_out <= custom ? own_p : pre_p;
         negative_gain_shift_out <= custom ? own_n : pre_n;
         offset_out <= custom ? own_off : pre_off;
         dac_code_out <= dac_q;
         ref_internal_out <= ~ref_q[1];
         ref_pin_oe_n_out <= ref_q != ssc_pkg::REF_INT_OUT;
      end
   end
endmodule // ssc_top

// ---- dv/ssc_chk.sv ----
// Port-level checks of the span config block
`timescale 1ns/1ps
module ssc_chk (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sdo_out,
   input wire logic spi_sdo_oe_n_out,
   input wire logic [2:0] span_select_out,
   input wire logic custom_span_out,
   input wire logic [1:0] positive_gain_shift_out,
   input wire logic [1:0] negative_gain_shift_out,
   input wire logic [9:0] offset_out,
   input wire logic [15:0] dac_code_out,
   input wire logic ref_internal_out,
   input wire logic ref_pin_oe_n_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   wire logic [9:0] pre_off;
   wire logic [1:0] pre_neg;
   assign pre_off = (span_select_out == 3'h1) ? ssc_pkg::PRE_OFF_5V :
      (span_select_out == 3'h2) ? ssc_pkg::PRE_OFF_10V :
      (span_select_out == 3'h3) ? ssc_pkg::PRE_OFF_PM5V :
      (span_select_out == 3'h4) ? ssc_pkg::PRE_OFF_PM10V :
      ssc_pkg::PRE_OFF_2V5;
   assign pre_neg = (span_select_out inside {3'h1, 3'h2, 3'h3, 3'h4}) ?
      2'h0 : ssc_pkg::PRE_N_2V5;
   sequence cs_idle8;
      spi_cs_n_in [*8];
   endsequence
   sequence quiet3;
      spi_sdo_oe_n_out [*3];
   endsequence
   idle_sdo_a: assert property (spi_cs_n_in |-> spi_sdo_oe_n_out)
      else $error("serial output driven while deselected");
   sdo_quiet_a: assert property (spi_cs_n_in |-> !spi_sdo_out)
      else $error("serial data not idle while deselected");
   frame_start_a: assert property (
      $fell(spi_cs_n_in) |-> quiet3)
      else $error("serial output driven in instruction phase");
   reset_vals_a: assert property ($rose(rst_n_in) |->
      span_select_out == 3'h0 && !custom_span_out && ref_internal_out &&
      ref_pin_oe_n_out && dac_code_out == 16'h0000)
      else $error("outputs wrong after reset");
   ref_pin_a: assert property (
      !ref_pin_oe_n_out |-> ref_internal_out)
      else $error("reference pin driven with external source");
   preset_a: assert property (!custom_span_out |->
      offset_out == pre_off && negative_gain_shift_out == pre_neg)
      else $error("preset offset or gain wrong");
   gain_fixed_a: assert property (!custom_span_out |->
      positive_gain_shift_out == 2'h0)
      else $error("preset positive gain wrong");
   offset_mag_a: assert property (
      custom_span_out |-> offset_out != 10'h200)
      else $error("custom offset beyond nine bit magnitude");
   quiet_hold_a: assert property (cs_idle8 |=>
      $stable(dac_code_out) && $stable(span_select_out))
      else $error("outputs changed with link idle");
endmodule // ssc_chk

// ---- dv/ssc_spi_host.sv ----
// Behavioural SPI host driving the block's serial port, mode 0
`timescale 1ns/1ps
module ssc_spi_host (
   output logic sclk_out,
   output logic cs_n_out,
   output logic sdi_out,
   input wire logic sdo_in
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   // Data changes while clock is low; the stray task pulses the clock outside frames
   task automatic frame(input logic [63:0] bits, input int n,
                        input int hp, output logic [63:0] got);
      got = '0;
      #13 cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_out = bits[i];
         #(hp) sclk_out = 1'b1;
         got = {got[62:0], sdo_in};
         #(hp) sclk_out = 1'b0;
      end
      #(hp) cs_n_out = 1'b1;
      sdi_out = ~sdi_out;
   endtask
   task automatic stray(input int n);
      repeat (n) begin
         sdi_out = ~sdi_out;
         #32 sclk_out = 1'b1;
         #32 sclk_out = 1'b0;
      end
   endtask
endmodule // ssc_spi_host

// ---- dv/spi_register_access_span_config_tb_top.sv ----
// Self-checking bench for the span config block
`timescale 1ns/1ps
module spi_register_access_span_config_tb_top;
   logic ref_clk_in = 1'b0;
   logic rst_n_in;
   logic sclk, cs_n, sdi, sdo, sdo_oe_n, custom, ref_int, ref_oe_n;
   logic [2:0] span;
   logic [1:0] pos, neg;
   logic [9:0] offs;
   logic [15:0] dac, d;
   logic [63:0] rx;
   logic [7:0] g, o;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_cycles = 0;
   int hp = 32;
   logic [6:0] rst_a[10] = '{7'h00, 7'h01, 7'h03, 7'h0a, 7'h0b, 7'h0c,
                              7'h0d, 7'h0e, 7'h0f, 7'h05};
   always #25 ref_clk_in = ~ref_clk_in;
   ssc_spi_host i_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
      .sdo_in(sdo));
   ssc_top i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .spi_clk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi),
      .spi_sdo_out(sdo), .spi_sdo_oe_n_out(sdo_oe_n),
      .span_select_out(span), .custom_span_out(custom),
      .positive_gain_shift_out(pos), .negative_gain_shift_out(neg),
      .offset_out(offs), .dac_code_out(dac), .ref_internal_out(ref_int),
      .ref_pin_oe_n_out(ref_oe_n));
   function automatic logic [11:0] f_pre(input logic [2:0] s);
      case (s)
         3'h1: return {2'h0, ssc_pkg::PRE_OFF_5V};
         3'h2: return {2'h0, ssc_pkg::PRE_OFF_10V};
         3'h3: return {2'h0, ssc_pkg::PRE_OFF_PM5V};
         3'h4: return {2'h0, ssc_pkg::PRE_OFF_PM10V};
         default: return {ssc_pkg::PRE_N_2V5, ssc_pkg::PRE_OFF_2V5};
      endcase
   endfunction
   function automatic logic [9:0] f_cust(input logic [7:0] gv, ov);
      logic [9:0] m;
      m = {1'b0, gv[0], ov};
      return gv[2] ? -m : m;
   endfunction
   task automatic tally_and_finish();
      $display("TB: %0d mismatches of %0d compared", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic run(input logic [63:0] b, input int n);
      i_host.frame(b, n, hp, rx);
      repeat (8) @(posedge ref_clk_in);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      run(64'({1'b0, a, v}), 16);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      run(64'({1'b1, a, 8'h00}), 16);
      chk({8'h00, rx[7:0]}, {8'h00, e}, "read");
   endtask
   always @(posedge ref_clk_in) begin
      n_cycles <= n_cycles + 1;
      if (n_cycles == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      rst_n_in = 1'b0;
      void'($urandom(32'hf309));
      repeat (12) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      foreach (rst_a[i]) begin
         rd_chk(rst_a[i], (i == 1) ? 8'h08 : 8'h00);
      end
      for (int s = 0; s < 8; s++) begin
         wr(7'h0b, 8'(s));
         chk({4'h0, neg, offs}, {4'h0, f_pre(3'(s))}, "preset");
         rd_chk(7'h0b, 8'(s));
      end
      i_host.stray(6);
      rd_chk(7'h0b, 8'h07);
      for (int k = 0; k < 5; k++) begin
         g = (k == 0) ? 8'hff : (8'($urandom) | 8'h80);
         o = (k == 0) ? 8'hff : 8'($urandom);
         wr(7'h0d, o);
         wr(7'h0c, g);
         chk({1'b0, custom, pos, neg, offs},
            {2'b01, g[6:5], g[4:3], f_cust(g, o)}, "custom");
         rd_chk(7'h0c, g & 8'hfd);
      end
      wr(7'h0c, 8'h00);
      chk({3'h0, custom, neg, offs}, {4'h0, f_pre(3'h7)},
         "override off");
      for (int r = 0; r < 4; r++) begin
         wr(7'h0a, 8'(r));
         chk({14'h0, ref_int, ref_oe_n}, {14'h0, r < 2, r != 1},
            "ref");
      end
      d = 16'($urandom);
      wr(7'h00, 8'h20);
      run(64'({1'b0, 7'h0e, d[7:0], d[15:8]}), 24);
      chk(dac, d, "dac up");
      d = 16'($urandom);
      wr(7'h00, 8'h00);
      run(64'({1'b0, 7'h0f, d[15:8], d[7:0]}), 24);
      chk(dac, d, "dac down");
      rd_chk(7'h03, 8'h00);
      wr(7'h0e, ~d[7:0]);
      chk(dac, d, "dac lone");
      rd_chk(7'h03, 8'h20);
      wr(7'h03, 8'h20);
      run(64'({1'b0, 7'h0b, 8'h02, 4'h5}), 20);
      chk({13'h0, span}, 16'h0002, "abort");
      rd_chk(7'h03, 8'h10);
      wr(7'h03, 8'h10);
      rd_chk(7'h03, 8'h00);
      wr(7'h01, 8'h88);
      run(64'({1'b0, 7'h0b, 8'h03, 1'b0, 7'h0a, 8'h01}), 32);
      chk({12'h0, span, ref_oe_n}, 16'h0006, "per access");
      wr(7'h01, 8'h00);
      run(64'({1'b0, 15'h000b, 8'h04}), 24);
      chk({13'h0, span}, 16'h0004, "long address");
      run(64'({1'b0, 15'h0001, 8'h08}), 24);
      rd_chk(7'h01, 8'h08);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      chk({13'h0, span}, 16'h0000, "second reset");
      rd_chk(7'h01, 8'h08);
      tally_and_finish();
   end
endmodule // spi_register_access_span_config_tb_top
bind ssc_top ssc_chk i_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
   .spi_cs_n_in(spi_cs_n_in), .spi_sdo_oe_n_out(spi_sdo_oe_n_out),
   .spi_sdo_out(spi_sdo_out),
   .span_select_out(span_select_out), .custom_span_out(custom_span_out),
   .positive_gain_shift_out(positive_gain_shift_out),
   .negative_gain_shift_out(negative_gain_shift_out),
   .offset_out(offset_out), .dac_code_out(dac_code_out),
   .ref_internal_out(ref_internal_out), .ref_pin_oe_n_out(ref_pin_oe_n_out));
